// ---- pdc_pkg.sv ----
// Purpose: shared constants for the idle and power-down controller
// Assumes: 10 MHz mclk, always-on while the core oscillator enable is low
// Notes: counts derive from printed times and the clock rate
package pdc_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int WAKE_DELAY_MS = 2;
	localparam int WAKE_DELAY_CYC = WAKE_DELAY_MS * (CLK_HZ / 1000);
	localparam int REENTRY_US = 4;
	localparam int REENTRY_CYC = (REENTRY_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int MC_DIV = 12;
	localparam int RESUME_MC = 2;
	localparam int TMR_W = 16;
	localparam int MC_W = 4;
	localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
	localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
	localparam logic [MC_W-1:0] MC_ZERO = 4'h0;
	localparam logic [MC_W-1:0] MC_ONE = 4'h1;
	localparam logic [1:0] RES_ZERO = 2'h0;
	localparam logic [1:0] RES_ONE = 2'h1;
	localparam logic [1:0] RESUME_LAST = 2'(RESUME_MC - 1);
	localparam logic STROBE_IDLE = 1'b1;
	localparam logic STROBE_PD = 1'b0;
	typedef enum {
		ST_RUN,
		ST_IDLE,
		ST_IDLE_RESUME,
		ST_RESET,
		ST_PD,
		ST_PD_RISE,
		ST_PD_TIMED
	} pm_state_e;
endpackage

// ---- cycle_divider.sv ----
// Purpose: machine-cycle enable pulse from mclk
// Assumes: run low holds the divider at its start
// Notes: one-cycle tick every MC_DIV clocks
`timescale 1ns/100ps
module cycle_divider
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	output logic tick
);
	logic [pdc_pkg::MC_W-1:0] cnt_reg;
	localparam logic [pdc_pkg::MC_W-1:0] LAST = pdc_pkg::MC_W'(pdc_pkg::MC_DIV - 1);

	always_ff @(posedge mclk)
	begin
		if (rst || !run || cnt_reg == LAST)
			cnt_reg <= pdc_pkg::MC_ZERO;
		else
			cnt_reg <= cnt_reg + pdc_pkg::MC_ONE;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || !run)
			tick <= 1'b0;
		else
			tick <= (cnt_reg == LAST);
	end
endmodule

// ---- down_timer.sv ----
// Purpose: loadable one-shot interval timer
// Assumes: load restarts the interval at any time
// Notes: done pulses one cycle when the count expires
`timescale 1ns/100ps
module down_timer
#(
	parameter logic [pdc_pkg::TMR_W-1:0] COUNT = 16'h0028
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic load,
	output logic busy,
	output logic done
);
	logic [pdc_pkg::TMR_W-1:0] cnt_reg;

	always_ff @(posedge mclk)
	begin
		if (rst)
			cnt_reg <= pdc_pkg::TMR_ZERO;
		else if (load)
			cnt_reg <= COUNT;
		else if (cnt_reg != pdc_pkg::TMR_ZERO)
			cnt_reg <= cnt_reg - pdc_pkg::TMR_ONE;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || load)
			done <= 1'b0;
		else
			done <= (cnt_reg == pdc_pkg::TMR_ONE);
	end

	assign busy = (cnt_reg != pdc_pkg::TMR_ZERO);
endmodule

// ---- idle_powerdown_control.sv ----
// Purpose: idle and power-down mode sequencer of the core
// Assumes: mclk keeps running for this block; oscEnable gates the core clock
// Notes: idleSet and pdSet are software write pulses of the mode request bits
// Operation
// - idle stops the core while peripherals, timers, serial port and interrupts run
// - idle is entered only by a software write from the running program
// - idle keeps RAM and special function registers unchanged
// - any enabled interrupt or hardware reset ends idle
// - reset out of idle lets the core run at most two machine cycles
// - during that run RAM writes are blocked, port access stays allowed
// - strobes high in idle, low in power-down; with external program memory port 0 floats, port 2 addresses in idle only
// - power-down stops the oscillator right after the requesting instruction if it comes 4 us or more after reset release or power-down exit
// - power-down keeps RAM and special function registers until exit
// - power-down ends only by hardware reset or enabled external interrupt
// - reset out of power-down reloads registers, leaves RAM untouched
// - wake edge select 1 starts service on the pin rising edge
// - wake edge select 0 starts after a 2 ms timed delay from falling edge
`timescale 1ns/100ps
module idle_powerdown_control
#(
	parameter int WAKE_CYC = pdc_pkg::WAKE_DELAY_CYC
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic idleSet,
	input wire logic pdSet,
	input wire logic wakeEdgeSelect,
	input wire logic anyIrqEnabled,
	input wire logic extIrq0Enable,
	input wire logic extIrq1Enable,
	input wire logic ext_irq0_pin,
	input wire logic ext_irq1_pin,
	input wire logic hwReset,
	input wire logic extProgMem,
	input wire logic cpuAle,
	input wire logic cpuFetchStrobe,
	output logic cpuRun,
	output logic peripheralRun,
	output logic oscEnable,
	output logic ramWriteEnable,
	output logic specialRegWriteEnable,
	output logic portAccessEnable,
	output logic specialRegReset,
	output logic isrStart,
	output logic idleRequest,
	output logic pdRequest,
	output logic aleOut,
	output logic program_fetch_strobe,
	output logic port0Float,
	output logic port2Address
);
	pdc_pkg::pm_state_e state_reg;
	pdc_pkg::pm_state_e stateNext;
	logic extLow;
	logic extLow_reg;
	logic extRise;
	logic mcTick;
	logic [1:0] resumeCnt_reg;
	logic wakeBusy;
	logic wakeDone;
	logic guardBusy;
	logic guardLoad;
	logic inResume;
	logic cpuRun_reg;
	logic periph_reg;
	logic osc_reg;
	logic ramWe_reg;
	logic specialWe_reg;
	logic portEn_reg;
	logic specialRst_reg;
	logic isr_reg;
	logic idleBit_reg;
	logic pdBit_reg;
	logic ale_reg;
	logic fetch_reg;
	logic p0Float_reg;
	logic p2Addr_reg;
	localparam logic [pdc_pkg::TMR_W-1:0] WAKE_LOAD = pdc_pkg::TMR_W'(WAKE_CYC);
	localparam logic [pdc_pkg::TMR_W-1:0] GUARD_LOAD = pdc_pkg::TMR_W'(pdc_pkg::REENTRY_CYC);

	function automatic logic coreRuns(input pdc_pkg::pm_state_e s);
		coreRuns = (s == pdc_pkg::ST_RUN) || (s == pdc_pkg::ST_IDLE_RESUME);
	endfunction

	function automatic logic inPowerDown(input pdc_pkg::pm_state_e s);
		inPowerDown = (s == pdc_pkg::ST_PD) || (s == pdc_pkg::ST_PD_RISE)
			|| (s == pdc_pkg::ST_PD_TIMED);
	endfunction

	// enabled external request, pins active low
	assign extLow = (extIrq0Enable && !ext_irq0_pin) || (extIrq1Enable && !ext_irq1_pin);
	assign extRise = extLow_reg && !extLow;
	assign inResume = (state_reg == pdc_pkg::ST_IDLE_RESUME);

	cycle_divider u_mc
	(
		.mclk(mclk),
		.rst(rst),
		.run(inResume),
		.tick(mcTick)
	);

	down_timer #(.COUNT(WAKE_LOAD)) u_wake
	(
		.mclk(mclk),
		.rst(rst),
		.load(state_reg == pdc_pkg::ST_PD && stateNext == pdc_pkg::ST_PD_TIMED),
		.busy(wakeBusy),
		.done(wakeDone)
	);

	down_timer #(.COUNT(GUARD_LOAD)) u_guard
	(
		.mclk(mclk),
		.rst(rst),
		.load(guardLoad),
		.busy(guardBusy),
		.done()
	);

	// guard restarts on code start after reset and on power-down exit
	assign guardLoad = (stateNext == pdc_pkg::ST_RUN)
		&& (state_reg == pdc_pkg::ST_RESET || inPowerDown(state_reg));

	always_comb
	begin
		stateNext = state_reg;
		case (state_reg)
			pdc_pkg::ST_RUN:
			begin
				if (hwReset)
					stateNext = pdc_pkg::ST_RESET;
				else if (pdSet && !guardBusy)
					stateNext = pdc_pkg::ST_PD;
				else if (idleSet)
					stateNext = pdc_pkg::ST_IDLE;
			end
			pdc_pkg::ST_IDLE:
			begin
				if (hwReset)
					stateNext = pdc_pkg::ST_IDLE_RESUME;
				else if (anyIrqEnabled)
					stateNext = pdc_pkg::ST_RUN;
			end
			pdc_pkg::ST_IDLE_RESUME:
			begin
				if (mcTick && resumeCnt_reg == pdc_pkg::RESUME_LAST)
					stateNext = pdc_pkg::ST_RESET;
			end
			pdc_pkg::ST_RESET:
			begin
				if (!hwReset)
					stateNext = pdc_pkg::ST_RUN;
			end
			pdc_pkg::ST_PD:
			begin
				if (hwReset)
					stateNext = pdc_pkg::ST_RESET;
				else if (extLow && wakeEdgeSelect)
					stateNext = pdc_pkg::ST_PD_RISE;
				else if (extLow)
					stateNext = pdc_pkg::ST_PD_TIMED;
			end
			pdc_pkg::ST_PD_RISE:
			begin
				if (hwReset)
					stateNext = pdc_pkg::ST_RESET;
				else if (extRise)
					stateNext = pdc_pkg::ST_RUN;
			end
			pdc_pkg::ST_PD_TIMED:
			begin
				if (hwReset)
					stateNext = pdc_pkg::ST_RESET;
				else if (wakeDone)
					stateNext = pdc_pkg::ST_RUN;
			end
			default:
				stateNext = pdc_pkg::ST_RESET;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			state_reg <= pdc_pkg::ST_RESET;
		else
			state_reg <= stateNext;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			extLow_reg <= 1'b0;
		else
			extLow_reg <= extLow;
	end

	// machine cycles the core still runs after reset hits idle
	always_ff @(posedge mclk)
	begin
		if (rst || !inResume)
			resumeCnt_reg <= pdc_pkg::RES_ZERO;
		else if (mcTick)
			resumeCnt_reg <= resumeCnt_reg + pdc_pkg::RES_ONE;
	end

	// core, clock and storage controls follow the next state
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cpuRun_reg <= 1'b0;
			periph_reg <= 1'b0;
			osc_reg <= 1'b1;
			ramWe_reg <= 1'b0;
			specialWe_reg <= 1'b0;
			portEn_reg <= 1'b0;
			specialRst_reg <= 1'b1;
		end
		else
		begin
			cpuRun_reg <= coreRuns(stateNext);
			periph_reg <= !inPowerDown(stateNext) && stateNext != pdc_pkg::ST_RESET;
			osc_reg <= stateNext != pdc_pkg::ST_PD;
			ramWe_reg <= stateNext == pdc_pkg::ST_RUN;
			specialWe_reg <= stateNext == pdc_pkg::ST_RUN;
			portEn_reg <= coreRuns(stateNext);
			specialRst_reg <= stateNext == pdc_pkg::ST_RESET;
		end
	end

	// service start after an interrupt wake
	always_ff @(posedge mclk)
	begin
		if (rst)
			isr_reg <= 1'b0;
		else
			isr_reg <= stateNext == pdc_pkg::ST_RUN && !guardLoad
				&& state_reg != pdc_pkg::ST_RUN || (guardLoad && state_reg != pdc_pkg::ST_RESET);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			idleBit_reg <= 1'b0;
			pdBit_reg <= 1'b0;
		end
		else
		begin
			idleBit_reg <= stateNext == pdc_pkg::ST_IDLE;
			pdBit_reg <= inPowerDown(stateNext);
		end
	end

	// strobe and port pin state per mode
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ale_reg <= 1'b0;
			fetch_reg <= 1'b0;
			p0Float_reg <= 1'b0;
			p2Addr_reg <= 1'b0;
		end
		else
		begin
			if (stateNext == pdc_pkg::ST_IDLE)
			begin
				ale_reg <= pdc_pkg::STROBE_IDLE;
				fetch_reg <= pdc_pkg::STROBE_IDLE;
			end
			else if (inPowerDown(stateNext))
			begin
				ale_reg <= pdc_pkg::STROBE_PD;
				fetch_reg <= pdc_pkg::STROBE_PD;
			end
			else
			begin
				ale_reg <= cpuAle;
				fetch_reg <= cpuFetchStrobe;
			end
			p0Float_reg <= extProgMem && (stateNext == pdc_pkg::ST_IDLE
				|| inPowerDown(stateNext));
			p2Addr_reg <= extProgMem && stateNext == pdc_pkg::ST_IDLE;
		end
	end

	assign cpuRun = cpuRun_reg;
	assign peripheralRun = periph_reg;
	assign oscEnable = osc_reg;
	assign ramWriteEnable = ramWe_reg;
	assign specialRegWriteEnable = specialWe_reg;
	assign portAccessEnable = portEn_reg;
	assign specialRegReset = specialRst_reg;
	assign isrStart = isr_reg;
	assign idleRequest = idleBit_reg;
	assign pdRequest = pdBit_reg;
	assign aleOut = ale_reg;
	assign program_fetch_strobe = fetch_reg;
	assign port0Float = p0Float_reg;
	assign port2Address = p2Addr_reg;

	localparam int RESUME_MAX = pdc_pkg::RESUME_MC * pdc_pkg::MC_DIV + 2;

	sequence s_resume_start;
		$rose(inResume);
	endsequence

	sequence s_reach_reset;
		##[1:RESUME_MAX] (state_reg == pdc_pkg::ST_RESET);
	endsequence

	property p_idle_core;
		@(posedge mclk) disable iff (rst)
		(state_reg == pdc_pkg::ST_IDLE) |-> (!cpuRun && peripheralRun && oscEnable);
	endproperty
	a_idle_core: assert property (p_idle_core) else $error("idle core not stopped");

	property p_idle_entry;
		@(posedge mclk) disable iff (rst)
		$rose(state_reg == pdc_pkg::ST_IDLE) |-> $past(idleSet) && $past(cpuRun);
	endproperty
	a_idle_entry: assert property (p_idle_entry) else $error("idle without write");

	property p_idle_hold;
		@(posedge mclk) disable iff (rst)
		(state_reg == pdc_pkg::ST_IDLE) |-> (!ramWriteEnable && !specialRegWriteEnable);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle storage written");

	property p_idle_wake;
		@(posedge mclk) disable iff (rst)
		(state_reg == pdc_pkg::ST_IDLE && anyIrqEnabled && !hwReset)
			|=> (state_reg == pdc_pkg::ST_RUN) && isrStart && cpuRun;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle not left on irq");

	property p_resume_bound;
		@(posedge mclk) disable iff (rst)
		s_resume_start |-> s_reach_reset;
	endproperty
	a_resume_bound: assert property (p_resume_bound) else $error("resume too long");

	property p_resume_ram;
		@(posedge mclk) disable iff (rst)
		inResume |-> (cpuRun && !ramWriteEnable && portAccessEnable);
	endproperty
	a_resume_ram: assert property (p_resume_ram) else $error("resume ram not blocked");

	property p_strobes;
		@(posedge mclk) disable iff (rst)
		(state_reg == pdc_pkg::ST_IDLE || inPowerDown(state_reg))
			|-> aleOut == program_fetch_strobe
			&& aleOut == ((state_reg == pdc_pkg::ST_IDLE) ? pdc_pkg::STROBE_IDLE
				: pdc_pkg::STROBE_PD)
			&& port0Float == $past(extProgMem)
			&& port2Address == ($past(extProgMem) && state_reg == pdc_pkg::ST_IDLE);
	endproperty
	a_strobes: assert property (p_strobes) else $error("mode pin state wrong");

	property p_pd_osc;
		@(posedge mclk) disable iff (rst)
		$rose(state_reg == pdc_pkg::ST_PD) |-> !oscEnable && !cpuRun && $past(cpuRun);
	endproperty
	a_pd_osc: assert property (p_pd_osc) else $error("oscillator not stopped");

	property p_pd_exit;
		@(posedge mclk) disable iff (rst)
		$fell(state_reg == pdc_pkg::ST_PD) |-> $past(hwReset) || $past(extLow);
	endproperty
	a_pd_exit: assert property (p_pd_exit) else $error("power-down left spuriously");

	property p_reset_regs;
		@(posedge mclk) disable iff (rst)
		(state_reg == pdc_pkg::ST_RESET) |-> (specialRegReset && !ramWriteEnable);
	endproperty
	a_reset_regs: assert property (p_reset_regs) else $error("reset not reloading");

	property p_rise_wake;
		@(posedge mclk) disable iff (rst)
		(state_reg == pdc_pkg::ST_PD_RISE && extRise && !hwReset) |=> isrStart && cpuRun;
	endproperty
	a_rise_wake: assert property (p_rise_wake) else $error("rising edge wake missed");

	property p_timed_wake;
		@(posedge mclk) disable iff (rst)
		$rose(state_reg == pdc_pkg::ST_PD_TIMED) |-> wakeBusy
			##1 (!cpuRun && state_reg == pdc_pkg::ST_PD_TIMED)[*4];
	endproperty
	a_timed_wake: assert property (p_timed_wake) else $error("timed wake too early");

	property p_req_clear;
		@(posedge mclk) disable iff (rst)
		(state_reg == pdc_pkg::ST_RUN) |-> (!idleRequest && !pdRequest);
	endproperty
	a_req_clear: assert property (p_req_clear) else $error("request bit not cleared");
endmodule

// ---- irq_reset_driver.sv ----
// Purpose: model of the reset source and external interrupt pin drivers
// Assumes: tasks are called just after a rising mclk edge
// Notes: pins rest high through their pull-ups
`timescale 1ns/100ps
module irq_reset_driver
#(
	parameter int START_CYC = 8,
	parameter int SETTLE_CYC = 8
)
(
	input wire logic mclk,
	output logic hwReset,
	output logic ext_irq0_pin,
	output logic ext_irq1_pin
);
	int lowCount = 0;
	int rstCount = 0;
	initial
	begin
		hwReset = 1'b0;
		ext_irq0_pin = 1'b1;
		ext_irq1_pin = 1'b1;
	end
	always @(posedge mclk)
	begin
		lowCount <= (ext_irq0_pin && ext_irq1_pin) ? 0 : lowCount + 1;
		rstCount <= hwReset ? rstCount + 1 : 0;
	end
	task automatic pinLow(input logic which);
		if (which)
			ext_irq1_pin = 1'b0;
		else
			ext_irq0_pin = 1'b0;
	endtask
	// pin stays low for the oscillator start-up time
	task automatic pinRelease();
		while (lowCount < START_CYC)
		begin
			@(posedge mclk);
			#1;
		end
		ext_irq0_pin = 1'b1;
		ext_irq1_pin = 1'b1;
	endtask
	task automatic resetOn();
		hwReset = 1'b1;
	endtask
	// reset held until the oscillator has settled
	task automatic resetOff();
		while (rstCount < SETTLE_CYC)
		begin
			@(posedge mclk);
			#1;
		end
		hwReset = 1'b0;
	endtask
endmodule

// ---- idle_powerdown_control_test.sv ----
// Purpose: self-checking bench of the idle and power-down sequencer
// Assumes: short timed wake-up for simulation
// Notes: random mode, pin and memory choices from a fixed seed
`timescale 1ns/100ps
module idle_powerdown_control_test;
	localparam int WAKE = 20;
	logic mclk = 1'b0, rst = 1'b1, idleSet = 1'b0, pdSet = 1'b0, wakeEdgeSelect = 1'b0;
	logic anyIrqEnabled = 1'b0, extIrq0Enable = 1'b0, extIrq1Enable = 1'b0, extProgMem = 1'b0;
	logic cpuAle = 1'b0, cpuFetchStrobe = 1'b0, prevAle, prevStrobe;
	logic hwReset, ext_irq0_pin, ext_irq1_pin, cpuRun, peripheralRun, oscEnable;
	logic ramWriteEnable, specialRegWriteEnable, portAccessEnable, specialRegReset, isrStart;
	logic idleRequest, pdRequest, aleOut, program_fetch_strobe, port0Float, port2Address;
	int miscompares = 0;
	int checkCount = 0;
	int n;
	logic ext, pin;
	idle_powerdown_control #(.WAKE_CYC(WAKE)) idle_powerdown_control_inst (.mclk(mclk),
		.rst(rst), .idleSet(idleSet), .pdSet(pdSet), .wakeEdgeSelect(wakeEdgeSelect),
		.anyIrqEnabled(anyIrqEnabled), .extIrq0Enable(extIrq0Enable),
		.extIrq1Enable(extIrq1Enable), .ext_irq0_pin(ext_irq0_pin),
		.ext_irq1_pin(ext_irq1_pin), .hwReset(hwReset), .extProgMem(extProgMem),
		.cpuAle(cpuAle), .cpuFetchStrobe(cpuFetchStrobe), .cpuRun(cpuRun),
		.peripheralRun(peripheralRun), .oscEnable(oscEnable), .ramWriteEnable(ramWriteEnable),
		.specialRegWriteEnable(specialRegWriteEnable), .portAccessEnable(portAccessEnable),
		.specialRegReset(specialRegReset), .isrStart(isrStart), .idleRequest(idleRequest),
		.pdRequest(pdRequest), .aleOut(aleOut), .program_fetch_strobe(program_fetch_strobe),
		.port0Float(port0Float), .port2Address(port2Address));
	irq_reset_driver irq_reset_driver_inst (.mclk(mclk), .hwReset(hwReset),
		.ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin));
	initial
	begin
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		prevAle = cpuAle;
		prevStrobe = cpuFetchStrobe;
		#1;
		cpuAle = 1'($urandom % 2);
		cpuFetchStrobe = 1'($urandom % 2);
	end
	// strobe and port status while asleep
	function automatic logic [3:0] pinStatus(input logic pd, input logic x);
		if (pd)
			return {pdc_pkg::STROBE_PD, pdc_pkg::STROBE_PD, x, 1'b0};
		return {pdc_pkg::STROBE_IDLE, pdc_pkg::STROBE_IDLE, x, x};
	endfunction
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic check(input logic [3:0] got, input logic [3:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		if (miscompares == 0 && checkCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic waitOut(input logic sel, output int k);
		logic v;
		k = 0;
		v = sel ? specialRegReset : cpuRun;
		while (v !== 1'b1 && k < 30000)
		begin
			step(1);
			k++;
			v = sel ? specialRegReset : cpuRun;
		end
		if (v !== 1'b1)
		begin
			miscompares++;
			results();
		end
	endtask
	task automatic goSleep(input logic pd, input logic x);
		extProgMem = x;
		if (pd)
			pdSet = 1'b1;
		else
			idleSet = 1'b1;
		step(1);
		pdSet = 1'b0;
		idleSet = 1'b0;
		check({idleRequest, pdRequest}, {~pd, pd});
		check({cpuRun, peripheralRun, oscEnable}, {1'b0, ~pd, ~pd});
		check({ramWriteEnable, specialRegWriteEnable}, 2'h0);
		check({aleOut, program_fetch_strobe, port0Float, port2Address}, pinStatus(pd, x));
		step(3);
		check({idleRequest, pdRequest, cpuRun}, {~pd, pd, 1'b0});
	endtask
	initial
	begin
		void'($urandom(4));
		repeat (16) @(posedge mclk);
		#1;
		check({specialRegReset, oscEnable, cpuRun}, 3'h6);
		rst = 1'b0;
		waitOut(1'b0, n);
		pdSet = 1'b1;
		step(1);
		pdSet = 1'b0;
		check({pdRequest, cpuRun}, 2'h1);
		for (int i = 0; i < 8; i++)
		begin
			goSleep(1'b0, 1'($urandom % 2));
			if ($urandom % 2)
			begin
				anyIrqEnabled = 1'b1;
				step(1);
				anyIrqEnabled = 1'b0;
				check({cpuRun, isrStart, idleRequest}, 3'h6);
				step(1);
				check(isrStart, 1'b0);
			end
			else
			begin
				irq_reset_driver_inst.resetOn();
				step(1);
				check({cpuRun, ramWriteEnable, portAccessEnable}, 3'h5);
				waitOut(1'b1, n);
				check(n >= pdc_pkg::MC_DIV && n <= pdc_pkg::RESUME_MC * pdc_pkg::MC_DIV + 1, 1);
				irq_reset_driver_inst.resetOff();
				waitOut(1'b0, n);
			end
		end
		for (int j = 0; j < 8; j++)
		begin
			step(pdc_pkg::REENTRY_CYC + 5);
			ext = 1'($urandom % 2);
			pin = 1'($urandom % 2);
			wakeEdgeSelect = 1'($urandom % 2);
			goSleep(1'b1, ext);
			anyIrqEnabled = 1'b1;
			{extIrq1Enable, extIrq0Enable} = {~pin, pin};
			irq_reset_driver_inst.pinLow(pin);
			step(3);
			check({oscEnable, pdRequest}, 2'h1);
			anyIrqEnabled = 1'b0;
			{extIrq1Enable, extIrq0Enable} = {pin, ~pin};
			step(1);
			check({oscEnable, cpuRun}, 2'h2);
			if (wakeEdgeSelect)
			begin
				step(3);
				check(cpuRun, 1'b0);
				irq_reset_driver_inst.pinRelease();
				step(1);
				check({cpuRun, isrStart, pdRequest}, 3'h6);
			end
			else
			begin
				waitOut(1'b0, n);
				check(n >= WAKE - 1 && n <= WAKE + 1, 1);
				check({isrStart, pdRequest}, 2'h2);
				irq_reset_driver_inst.pinRelease();
			end
			{extIrq1Enable, extIrq0Enable} = 2'h0;
		end
		step(pdc_pkg::REENTRY_CYC + 5);
		goSleep(1'b1, 1'b1);
		irq_reset_driver_inst.resetOn();
		step(1);
		check({specialRegReset, isrStart, pdRequest}, 3'h4);
		irq_reset_driver_inst.resetOff();
		waitOut(1'b0, n);
		check(isrStart, 1'b0);
		step(2);
		check({aleOut, program_fetch_strobe, port0Float}, {prevAle, prevStrobe, 1'b0});
		results();
	end
endmodule
